// ---- hdl/overlay_invalidate_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module overlay_invalidate_host (
  // Clock, reset, enable
  input  wire logic                                   clock,
  input  wire logic                                   rst,
  input  wire logic                                   ce,
  // APB slave
  input  wire logic [dcache_overlay_pkg::APB_AW-1:0]  paddr,
  input  wire logic                                   psel,
  input  wire logic                                   penable,
  input  wire logic                                   pwrite,
  input  wire logic [31:0]                            pwdata,
  output logic [31:0]                                 prdata_q,
  output logic                                        pready_q,
  output logic                                        pslverr_q,
  // Load/store unit
  input  wire logic                                   lsu_store_valid,
  input  wire logic [dcache_overlay_pkg::IDX_W-1:0]   lsu_store_index,
  output logic                                        lsu_store_ready_q,
  output logic                                        irq_masked_q,
  // Link to the cache
  ovl_link.host                                       link
);
  import dcache_overlay_pkg::*;

  // ********************************************************************
  // Declarations
  // ********************************************************************
  seq_e              seq_q;
  seq_e              seq_d;
  logic              req_q;
  logic              we_q;
  logic [31:0]       wdata_q;
  logic              st_valid_q;
  logic [IDX_W-1:0]  st_index_q;
  logic [31:0]       readback_q;
  logic              done_q;
  logic              setup;
  logic              apb_write;
  logic              start_cmd;
  logic              apb_store;
  logic              lsu_store;

  // ********************************************************************
  // APB decode
  // ********************************************************************
  assign setup     = psel && !penable;
  assign apb_write = psel && penable && pready_q && pwrite;
  assign start_cmd = apb_write && (paddr == CMD_OFS) && pwdata[CMD_START_BIT] && seq_q == S_IDLE;
  assign apb_store = apb_write && (paddr == STORE_OFS) && seq_q == S_IDLE;
  assign lsu_store = lsu_store_valid && lsu_store_ready_q;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end
    else if (ce)
    begin
      pready_q <= setup;
      if (setup && !pwrite)
        unique case (paddr)
          STATUS_OFS:   prdata_q <= {30'h0, done_q, seq_q != S_IDLE};
          READBACK_OFS: prdata_q <= readback_q;
          default:      prdata_q <= '0;
        endcase
    end
  end

  // ********************************************************************
  // Store issue
  // ********************************************************************
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      st_valid_q <= 1'b0;
      st_index_q <= '0;
    end
    else if (ce)
    begin
      st_valid_q <= lsu_store || apb_store;
      if (lsu_store)
        st_index_q <= lsu_store_index;
      else if (apb_store)
        st_index_q <= pwdata[IDX_W-1:0];
    end
  end

  // Stores and interrupts are held off for the whole sequence
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      lsu_store_ready_q <= 1'b0;
      irq_masked_q      <= 1'b0;
    end
    else if (ce)
    begin
      lsu_store_ready_q <= (seq_d == S_IDLE); // RL11
      irq_masked_q      <= (seq_d != S_IDLE); // RL11
    end
  end

  // ********************************************************************
  // Trigger sequence
  // ********************************************************************
  always_comb
  begin
    seq_d = seq_q;
    unique case (seq_q)
      S_IDLE:  if (start_cmd) seq_d = S_DRAIN;
      S_DRAIN: if (!st_valid_q) seq_d = S_READ; // RL9
      S_READ:  if (link.ack) seq_d = S_WRITE;
      S_WRITE: if (link.ack) seq_d = S_CHECK;
      S_CHECK: if (link.ack) seq_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      seq_q <= S_IDLE;
    else if (ce)
      seq_q <= seq_d;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      req_q   <= 1'b0;
      we_q    <= 1'b0;
      wdata_q <= '0;
    end
    else if (ce)
    begin
      if (seq_q == S_DRAIN && !st_valid_q)
      begin
        req_q <= 1'b1;
        we_q  <= 1'b0;
      end
      else if (seq_q == S_READ && link.ack)
      begin
        we_q    <= 1'b1;
        wdata_q <= {TRIGGER_UPPER, link.rdata[SOV_W-1:0]}; // RL7 RL8
      end
      else if (seq_q == S_WRITE && link.ack)
        we_q <= 1'b0; // RL10
      else if (seq_q == S_CHECK && link.ack)
        req_q <= 1'b0;
    end
  end

  // Sticky done: set by the read-back, cleared by writing one; set wins
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      readback_q <= '0;
      done_q     <= 1'b0;
    end
    else if (ce)
    begin
      if (seq_q == S_CHECK && link.ack)
      begin
        readback_q <= link.rdata;
        done_q     <= 1'b1;
      end
      else if (apb_write && paddr == STATUS_OFS && pwdata[STAT_DONE_BIT])
        done_q <= 1'b0;
    end
  end

  assign link.req      = req_q;
  assign link.we       = we_q;
  assign link.addr     = OVERLAY_CONTROL_ADDR;
  assign link.wdata    = wdata_q;
  assign link.st_valid = st_valid_q;
  assign link.st_index = st_index_q;

endmodule // overlay_invalidate_host
`default_nettype wire

// ---- include/dcache_overlay_pkg.sv ----
package dcache_overlay_pkg;

  // ********************************************************************
  // Cache geometry
  // ********************************************************************
  localparam int LINES = 16;
  localparam int IDX_W = 4;

  // ********************************************************************
  // Overlay control register
  // ********************************************************************
  localparam logic [31:0] OVERLAY_CONTROL_ADDR  = 32'hF87FFBE0;
  localparam logic [31:0] OVERLAY_CONTROL_RESET = 32'h00000000;
  localparam int          SOV_W                 = 16;
  localparam int          START_BIT             = 16;
  localparam int          SELECT_BIT            = 18;
  localparam int          INVAL_BIT             = 24;
  localparam int          DONE_BIT              = 25;
  localparam logic [15:0] TRIGGER_UPPER         = 16'h0305;

  // ********************************************************************
  // Controller registers on APB
  // ********************************************************************
  localparam int         APB_AW         = 8;
  localparam logic [7:0] CMD_OFS        = 8'h00;
  localparam logic [7:0] STATUS_OFS     = 8'h04;
  localparam logic [7:0] STORE_OFS      = 8'h08;
  localparam logic [7:0] READBACK_OFS   = 8'h0C;
  localparam int         CMD_START_BIT  = 0;
  localparam int         STAT_BUSY_BIT  = 0;
  localparam int         STAT_DONE_BIT  = 1;

  // ********************************************************************
  // Trigger sequence states
  // ********************************************************************
  typedef enum logic [2:0] {S_IDLE, S_DRAIN, S_READ, S_WRITE, S_CHECK} seq_e;

endpackage

// ---- include/ovl_link.sv ----
`timescale 1ns/1ps
`default_nettype none
interface ovl_link (
  input wire logic clock,
  input wire logic rst
);
  import dcache_overlay_pkg::*;

  logic             req;
  logic             we;
  logic [31:0]      addr;
  logic [31:0]      wdata;
  logic [31:0]      rdata;
  logic             ack;
  logic             st_valid;
  logic [IDX_W-1:0] st_index;

  modport device (input req, we, addr, wdata, st_valid, st_index, output rdata, ack);
  modport host   (output req, we, addr, wdata, st_valid, st_index, input rdata, ack);
endinterface
`default_nettype wire

// ---- hdl/dcache_line_cell.sv ----
`timescale 1ns/1ps
`default_nettype none
module dcache_line_cell (
  // Clock, reset, enable
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic ce,
  // Line events
  input  wire logic store_hit,
  input  wire logic fill_hit,
  input  wire logic clean_hit,
  input  wire logic invalidate,
  // Line state
  output logic      valid_q,
  output logic      dirty_q
);
  logic valid_d;
  logic dirty_d;

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb
  begin
    valid_d = valid_q;
    dirty_d = dirty_q;
    if (store_hit)
    begin
      valid_d = 1'b1; // RL3 RL4 RL5
      dirty_d = 1'b1; // RL3 RL4
    end
    else
    begin
      if (fill_hit)
      begin
        valid_d = 1'b1;
        dirty_d = 1'b0;
      end
      else if (clean_hit)
        dirty_d = 1'b0;
      // Only lines clean at the end of the cycle are dropped
      if (invalidate && !dirty_d)
        valid_d = 1'b0; // RL1 RL2 RL5
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      valid_q <= 1'b0;
      dirty_q <= 1'b0;
    end
    else if (ce)
    begin
      valid_q <= valid_d;
      dirty_q <= dirty_d;
    end
  end
endmodule // dcache_line_cell
`default_nettype wire

// ---- hdl/dcache_overlay_invalidate.sv ----
// Overview of operation
// RL1: Invalidate write drops clean lines in one cycle
// RL2: Invalidate makes valid clean lines invalid, skips dirty
// RL3: A store leaves its line valid and dirty
// RL4: Store colliding with invalidate still sets dirty
// RL5: Colliding store line stays valid; invalidate spares it
// RL6: Hardware sets config-done when invalidate is performed
// RL7: Software reads control, keeps shared overlay enable field
// RL8: New value sets invalidate, start and config bits
// RL9: Software drains all stores before the invalidate write
// RL10: Software reads control back after writing it
// RL11: Trigger sequence runs with interrupts disabled
`timescale 1ns/1ps
`default_nettype none
module dcache_overlay_invalidate (
  // Clock, reset, enable
  input  wire logic                                  clock,
  input  wire logic                                  rst,
  input  wire logic                                  ce,
  // Link to the CPU side
  ovl_link.device                                    link,
  // Line refill
  input  wire logic                                  fill_valid,
  input  wire logic [dcache_overlay_pkg::IDX_W-1:0]  fill_index,
  // Line writeback
  input  wire logic                                  clean_valid,
  input  wire logic [dcache_overlay_pkg::IDX_W-1:0]  clean_index,
  // Line probe
  input  wire logic [dcache_overlay_pkg::IDX_W-1:0]  probe_index,
  output logic                                       probe_valid_q,
  output logic                                       probe_dirty_q,
  // Whole cache state
  output logic [dcache_overlay_pkg::LINES-1:0]       valid_map_q,
  output logic [dcache_overlay_pkg::LINES-1:0]       dirty_map_q,
  // Overlay state
  output logic                                       overlay_start_q,
  output logic                                       overlay_config_done_q,
  output logic                                       invalidate_seen_q
);
  import dcache_overlay_pkg::*;

  // ********************************************************************
  // Declarations
  // ********************************************************************
  logic              ack_q;
  logic [31:0]       rdata_q;
  logic [SOV_W-1:0]  shared_overlay_enable_field_q;
  logic              overlay_select_q;
  logic              accept;
  logic              addr_hit;
  logic              reg_write;
  logic              cache_invalidate_request;
  logic [31:0]       control_word;
  logic [LINES-1:0]  store_sel;
  logic [LINES-1:0]  fill_sel;
  logic [LINES-1:0]  clean_sel;

  // ********************************************************************
  // Index decoding
  // ********************************************************************
  function automatic logic [LINES-1:0] line_select(
    input logic             en,
    input logic [IDX_W-1:0] idx
  );
    logic [LINES-1:0] sel;
    sel      = '0;
    sel[idx] = en;
    return sel;
  endfunction

  assign store_sel = line_select(link.st_valid, link.st_index);
  assign fill_sel  = line_select(fill_valid, fill_index);
  assign clean_sel = line_select(clean_valid, clean_index);

  // ********************************************************************
  // Register access decode
  // ********************************************************************
  // A request is taken once; the cycle of its answer does not count
  assign accept    = link.req && !ack_q;
  assign addr_hit  = (link.addr == OVERLAY_CONTROL_ADDR);
  assign reg_write = accept && link.we && addr_hit;

  // Single cycle bulk invalidate on the write itself
  assign cache_invalidate_request = reg_write && link.wdata[INVAL_BIT]; // RL1

  always_comb
  begin
    control_word             = OVERLAY_CONTROL_RESET;
    control_word[SOV_W-1:0]  = shared_overlay_enable_field_q;
    control_word[START_BIT]  = overlay_start_q;
    control_word[SELECT_BIT] = overlay_select_q;
    control_word[DONE_BIT]   = overlay_config_done_q;
    // The invalidate request is a strobe and is never stored
    control_word[INVAL_BIT]  = 1'b0;
  end

  // ********************************************************************
  // Line state array
  // ********************************************************************
  // Every line sees the same invalidate strobe in the cycle it is written
  generate
    for (genvar i = 0; i < LINES; i++)
    begin : g_line
      dcache_line_cell u_cell (
        .clock      (clock),
        .rst        (rst),
        .ce         (ce),
        .store_hit  (store_sel[i]),
        .fill_hit   (fill_sel[i]),
        .clean_hit  (clean_sel[i]),
        .invalidate (cache_invalidate_request),
        .valid_q    (valid_map_q[i]),
        .dirty_q    (dirty_map_q[i])
      );
    end
  endgenerate

  // ********************************************************************
  // Overlay control fields
  // ********************************************************************
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      shared_overlay_enable_field_q <= OVERLAY_CONTROL_RESET[SOV_W-1:0];
    else if (ce && reg_write)
      shared_overlay_enable_field_q <= link.wdata[SOV_W-1:0];
  end

  // Start and select follow the written word
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      overlay_start_q  <= OVERLAY_CONTROL_RESET[START_BIT];
      overlay_select_q <= OVERLAY_CONTROL_RESET[SELECT_BIT];
    end
    else if (ce && reg_write)
    begin
      overlay_start_q  <= link.wdata[START_BIT];
      overlay_select_q <= link.wdata[SELECT_BIT];
    end
  end

  // Set by the invalidate, cleared by writing zero; the set wins
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      overlay_config_done_q <= OVERLAY_CONTROL_RESET[DONE_BIT];
    else if (ce)
    begin
      if (cache_invalidate_request)
        overlay_config_done_q <= 1'b1; // RL6
      else if (reg_write && !link.wdata[DONE_BIT])
        overlay_config_done_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      invalidate_seen_q <= 1'b0;
    else if (ce)
      invalidate_seen_q <= cache_invalidate_request;
  end

  // ********************************************************************
  // Register answer
  // ********************************************************************
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      ack_q <= 1'b0;
    else if (ce)
      ack_q <= accept;
  end

  // Unmapped addresses read as zero; the invalidate bit reads as zero
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      rdata_q <= '0;
    else if (ce && accept && !link.we)
    begin
      if (addr_hit)
        rdata_q <= control_word;
      else
        rdata_q <= '0;
    end
  end

  assign link.ack   = ack_q;
  assign link.rdata = rdata_q;

  // ********************************************************************
  // Line probe
  // ********************************************************************
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      probe_valid_q <= 1'b0;
      probe_dirty_q <= 1'b0;
    end
    else if (ce)
    begin
      probe_valid_q <= valid_map_q[probe_index];
      probe_dirty_q <= dirty_map_q[probe_index];
    end
  end

endmodule // dcache_overlay_invalidate
`default_nettype wire

// ---- tb/dcache_overlay_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module dcache_overlay_sva (
  // Clock and reset
  input wire logic                                  clock,
  input wire logic                                  rst,
  // Link signals
  input wire logic                                  req,
  input wire logic                                  we,
  input wire logic [31:0]                           addr,
  input wire logic [31:0]                           wdata,
  input wire logic [31:0]                           rdata,
  input wire logic                                  ack,
  input wire logic                                  st_valid,
  input wire logic [dcache_overlay_pkg::IDX_W-1:0]  st_index
);
  import dcache_overlay_pkg::*;
  logic [15:0] low_q;
  logic        wrote_q;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Lower field of the last word read
  always_ff @(posedge clock or posedge rst)
    if (rst) low_q <= 16'h0000;
    else if (ack && !we) low_q <= rdata[15:0];
  // Set by a write, cleared by the next read
  always_ff @(posedge clock or posedge rst)
    if (rst) wrote_q <= 1'b0;
    else if (ack) wrote_q <= we;
  ack_timing_a: assert property (req && !ack |=> ack)
    else $error("link answer late");
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("link answer stuck");
  req_hold_a: assert property (req && !ack |=> req && $stable(we) && $stable(wdata))
    else $error("link request dropped early");
  ctl_addr_a: assert property (req |-> addr == OVERLAY_CONTROL_ADDR)
    else $error("link address wrong");
  trig_value_a: assert property (req && we |-> wdata[31:16] == TRIGGER_UPPER)
    else $error("trigger upper half wrong");
  keep_field_a: assert property (req && we |-> wdata[15:0] == low_q)
    else $error("shared field not kept");
  no_store_a: assert property (req && we |-> !st_valid)
    else $error("store during invalidate");
  read_back_a: assert property (ack && we |-> ##[1:4] (req && !we && !ack))
    else $error("no read back");
  done_set_a: assert property (ack && !we && wrote_q |-> rdata[DONE_BIT] && !rdata[INVAL_BIT])
    else $error("done bit missing");
  cover property (ack && we);
  cover property (ack && !we && wrote_q);
  cover property (st_valid && st_index == 4'hF);
endmodule // dcache_overlay_sva
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHECK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: %h vs %h", $time, (a), (e)); end end
module testbench;
  import dcache_overlay_pkg::*;
  // ********
  // Harness
  // ********
  logic clock = 1'b0, rst = 1'b1, ce = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata_q, r;
  logic pready_q, lsu_store_ready_q, irq_masked_q;
  logic lsu_store_valid = 1'b0, fill_valid = 1'b0, clean_valid = 1'b0;
  logic [IDX_W-1:0] lsu_store_index = '0, fill_index = '0, clean_index = '0, probe_index = '0, i;
  logic [LINES-1:0] vmap, dmap, vmap_b, dmap_b, vm, dm, vm_b, dm_b;
  logic probe_v, probe_d, start_q, done_q, done_b, pslverr, seen, seen_b;
  int mismatches = 0, comparisons = 0, k, n, seen_n = 0, seen_n_b = 0;

  always #12.5 clock = ~clock;

  // Invalidate pulses seen by each cache
  always @(posedge clock)
  begin
    if (seen === 1'b1) seen_n++;
    if (seen_b === 1'b1) seen_n_b++;
  end

  ovl_link link (.clock(clock), .rst(rst));
  ovl_link link_b (.clock(clock), .rst(rst));

  dcache_overlay_invalidate u_dcache_overlay_invalidate (.clock(clock), .rst(rst), .ce(ce),
    .link(link), .fill_valid(fill_valid), .fill_index(fill_index), .clean_valid(clean_valid),
    .clean_index(clean_index), .probe_index(probe_index), .probe_valid_q(probe_v),
    .probe_dirty_q(probe_d), .valid_map_q(vmap), .dirty_map_q(dmap),
    .overlay_start_q(start_q), .overlay_config_done_q(done_q), .invalidate_seen_q(seen));
  dcache_overlay_invalidate u_dcache_overlay_invalidate_b (.clock(clock), .rst(rst), .ce(ce),
    .link(link_b), .fill_valid(fill_valid), .fill_index(fill_index),
    .clean_valid(clean_valid), .clean_index(clean_index), .probe_index(probe_index),
    .probe_valid_q(), .probe_dirty_q(), .valid_map_q(vmap_b), .dirty_map_q(dmap_b),
    .overlay_start_q(), .overlay_config_done_q(done_b), .invalidate_seen_q(seen_b));
  overlay_invalidate_host u_overlay_invalidate_host (.clock(clock), .rst(rst), .ce(ce),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr),
    .lsu_store_valid(lsu_store_valid),
    .lsu_store_index(lsu_store_index), .lsu_store_ready_q(lsu_store_ready_q),
    .irq_masked_q(irq_masked_q), .link(link));
  dcache_overlay_sva u_dcache_overlay_sva (.clock(clock), .rst(rst), .req(link.req),
    .we(link.we), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack),
    .st_valid(link.st_valid), .st_index(link.st_index));

  task automatic summarize;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Control word read after a trigger with the given lower field
  function automatic logic [31:0] ctl_expect(input logic [15:0] low);
    logic [31:0] w;
    w = {TRIGGER_UPPER, low};
    w[INVAL_BIT] = 1'b0;
    return w;
  endfunction

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int c = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready_q !== 1'b1 && ++c < 20);
    r = prdata_q;
    if (c >= 20) mismatches++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic lsu(input logic [IDX_W-1:0] x);
    int c = 0;
    @(posedge clock);
    lsu_store_valid <= 1'b1;
    lsu_store_index <= x;
    do @(posedge clock); while (lsu_store_ready_q !== 1'b1 && ++c < 40);
    if (c >= 40) mismatches++;
    lsu_store_valid <= 1'b0;
    vm[x] = 1'b1;
    dm[x] = 1'b1;
  endtask

  // Fill or writeback reaches both caches
  task automatic line_ev(input logic f, input logic [IDX_W-1:0] x);
    @(posedge clock);
    fill_valid <= f;
    clean_valid <= !f;
    fill_index <= x;
    clean_index <= x;
    @(posedge clock);
    fill_valid <= 1'b0;
    clean_valid <= 1'b0;
    vm[x] = vm[x] | f;
    vm_b[x] = vm_b[x] | f;
    dm[x] = 1'b0;
    dm_b[x] = 1'b0;
  endtask

  // Bench stands in for the host on the second link
  task automatic drv_b(input logic w, input logic [31:0] d, input logic st,
                       input logic [IDX_W-1:0] x);
    int c = 0;
    @(posedge clock);
    link_b.req <= 1'b1;
    link_b.we <= w;
    link_b.wdata <= d;
    link_b.st_valid <= st;
    link_b.st_index <= x;
    @(posedge clock);
    link_b.st_valid <= 1'b0;
    while (link_b.ack !== 1'b1 && c++ < 20) @(posedge clock);
    if (link_b.ack !== 1'b1) mismatches++;
    r = link_b.rdata;
    link_b.req <= 1'b0;
    link_b.wdata <= ~d;
    #1;
  endtask

  // ********
  // Tests
  // ********
  initial
  begin
    #750000;
    mismatches++;
    summarize();
  end

  initial
  begin
    void'($urandom(80573));
    link_b.req = 1'b0;
    link_b.we = 1'b0;
    link_b.addr = OVERLAY_CONTROL_ADDR;
    link_b.wdata = 32'h0;
    link_b.st_valid = 1'b0;
    link_b.st_index = '0;
    vm = '0;
    dm = '0;
    vm_b = '0;
    dm_b = '0;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    for (int round = 0; round < 3; round++)
    begin
      repeat (10)
      begin
        k = $urandom_range(0, 3);
        i = IDX_W'($urandom_range(0, LINES - 1));
        case (k)
          0: lsu(i);
          1: line_ev(1'b1, i);
          2: line_ev(1'b0, i);
          default:
          begin
            apb(1'b1, STORE_OFS, {28'h0, i});
            vm[i] = 1'b1;
            dm[i] = 1'b1;
          end
        endcase
        repeat (3) @(posedge clock);
      end
      probe_index <= i;
      repeat (2) @(posedge clock);
      #1;
      `CHECK({probe_v, probe_d}, {vm[i], dm[i]})
      `CHECK(vmap, vm)
      `CHECK(dmap, dm)
      apb(1'b1, STATUS_OFS, 32'h2);
      apb(1'b1, CMD_OFS, 32'h1);
      @(posedge clock);
      #1;
      `CHECK(irq_masked_q, 1'b1)
      r = '0;
      n = 0;
      while (r[STAT_DONE_BIT] !== 1'b1 && n++ < 40) apb(1'b0, STATUS_OFS, 32'h0);
      `CHECK(r[STAT_DONE_BIT], 1'b1)
      `CHECK(seen_n, round + 1)
      vm = vm & dm;
      `CHECK(vmap, vm)
      `CHECK(dmap, dm)
      `CHECK({start_q, done_q}, 2'b11)
      apb(1'b0, READBACK_OFS, 32'h0);
      `CHECK(r, ctl_expect(16'h0000))
    end
    // A fill while the clock enable is low must change nothing
    @(posedge clock);
    ce <= 1'b0;
    fill_valid <= 1'b1;
    fill_index <= ~i;
    repeat (3) @(posedge clock);
    fill_valid <= 1'b0;
    ce <= 1'b1;
    #1;
    `CHECK(vmap, vm)
    apb(1'b0, 8'h10, 32'h0);
    `CHECK(r, 32'h0)
    `CHECK(pslverr, 1'b0)
    drv_b(1'b1, 32'h0000A5C3, 1'b0, 4'h0);
    `CHECK(done_b, 1'b0)
    drv_b(1'b0, 32'h0, 1'b1, 4'h5);
    `CHECK(r, 32'h0000A5C3)
    vm_b[5] = 1'b1;
    dm_b[5] = 1'b1;
    for (int p = 0; p < 2; p++)
    begin
      i = p ? 4'h9 : 4'h2;
      line_ev(1'b1, 4'h3);
      line_ev(1'b1, 4'h2);
      if (p) line_ev(1'b0, 4'h9);
      drv_b(1'b1, {TRIGGER_UPPER, 16'hA5C3}, 1'b1, i);
      vm_b[i] = 1'b1;
      dm_b[i] = 1'b1;
      vm_b = vm_b & dm_b;
      `CHECK(vmap_b, vm_b)
      `CHECK(dmap_b, dm_b)
      `CHECK(done_b, 1'b1)
    end
    `CHECK(seen_n_b, 2)
    drv_b(1'b0, 32'h0, 1'b0, 4'h0);
    `CHECK(r, ctl_expect(16'hA5C3))
    summarize();
  end
endmodule // testbench
`default_nettype wire
